// [rtl/e1_ctrl_pkg.sv]
// Purpose: shared constants for the e1 error insertion and global control block
// Assumes: apb byte address is four times the register index
// Notes: reset values of both control words are all zeros
package e1_ctrl_pkg;
    // ----------------------------------------------------------------
    // register indexes and bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_ERR_INS = 8'h19;
    localparam logic [7:0] IDX_GLOBAL = 8'h1a;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    // ----------------------------------------------------------------
    // error insertion word fields
    // ----------------------------------------------------------------
    localparam int EI_BPV = 7;
    localparam int EI_CRC = 6;
    localparam int EI_FAS = 5;
    localparam int EI_NFAS = 4;
    localparam int EI_ZERO = 3;
    localparam int EI_PAYLOAD = 2;
    localparam int EI_DEAD_SEL = 0;
    localparam logic [7:0] EI_WRITE_MASK = 8'hfd;
    localparam logic [7:0] ERR_INS_RESET = 8'h00;
    // ----------------------------------------------------------------
    // global control word fields
    // ----------------------------------------------------------------
    localparam int GC_RESET = 7;
    localparam int GC_SUSPEND = 6;
    localparam int GC_ACK = 5;
    localparam int GC_CNT_CLR = 4;
    localparam int GC_SAMPLE = 3;
    localparam int GC_EXT_OSC = 2;
    localparam int GC_MUST_ZERO = 1;
    localparam logic [7:0] GC_WRITE_MASK = 8'hfe;
    localparam logic [7:0] GLOBAL_RESET = 8'h00;
    // ----------------------------------------------------------------
    // one-shot slots and interrupt status layout
    // ----------------------------------------------------------------
    localparam int SHOT_N = 5;
    localparam int SH_BPV = 0;
    localparam int SH_CRC = 1;
    localparam int SH_FAS = 2;
    localparam int SH_NFAS = 3;
    localparam int SH_PAYLOAD = 4;
    localparam int IRQ_W = 3;
    localparam int ST_DEAD_RISE = 0;
    localparam int ST_DEAD_FALL = 1;
    localparam int ST_SHOT_DONE = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
endpackage

// [rtl/shot_if.sv]
// Purpose: bundle between the control register owner and the one-shot bank
// Assumes: one clock domain
// Notes: wr is a one-cycle write strobe of the owning register
`timescale 1ns/1ps
interface shot_if #(parameter int N = 5);
    logic wr;              // write strobe
    logic flush;           // drop all pending shots
    logic [N-1:0] new_bits; // value being written
    logic [N-1:0] old_bits; // value held before the write
    logic [N-1:0] opp;     // insertion opportunity strobes
    logic [N-1:0] pending; // armed, waiting for opportunity
    logic [N-1:0] fire;    // one-cycle insertion pulse
    modport bank (input wr, flush, new_bits, old_bits, opp, output pending, fire);
    modport owner (output wr, flush, new_bits, old_bits, opp, input pending, fire);
endinterface

// [rtl/one_shot_bank.sv]
// Purpose: arms a single insertion on each rising change of a written bit
// Assumes: opp strobes come from the transmit framer on the same clock
// Notes: an arm in the same cycle as a fire keeps the new request
`timescale 1ns/1ps
module one_shot_bank #(
    parameter int N = 5
) (
    input wire logic i_clk_sys, // system clock
    input wire logic i_srst,    // synchronous reset
    shot_if.bank sif            // bundle to owner
);
    // ----------------------------------------------------------------
    // arm and fire
    // ----------------------------------------------------------------
    logic [N-1:0] pending;
    logic [N-1:0] fire;
    wire [N-1:0] rise = sif.wr ? (sif.new_bits & ~sif.old_bits) : '0;
    wire [N-1:0] take = pending & sif.opp;
    wire [N-1:0] next_pending = (pending & ~take) | rise;

    // refused at elaboration: the slot vectors are sized for one to eight shots
    if (N < 1 || N > 8) begin : g_bad_n
        $error("one_shot_bank: N must be 1 to 8");
    end

    // new arm wins over the consumed one so no request is lost
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || sif.flush) begin
            pending <= '0;
            fire <= '0;
        end else begin
            pending <= next_pending;
            fire <= take;
        end
    end

    assign sif.pending = pending;
    assign sif.fire = fire;
endmodule

// [rtl/e1_err_ctrl.sv]
// Purpose: e1 error insertion word and global control word behind apb
// Assumes: framer status and opportunity strobes are on i_clk_sys
// Notes: apb answers with pready in the first access cycle
// Operation
// - bpv bit rising inserts one violation
// - crc bit rising corrupts one crc-4 check
// - fas bit rising corrupts one alignment word
// - nfas bit rising flips nfas bit two once
// - zero bit high sends no pulses
// - payload bit rising inserts one payload error
// - select high: dead line on signal loss
// - select low: signal loss or frame loss
// - reset bit rising restores defaults
// - suspend floats interrupt, ignores sources
// - acknowledge toggle clears pending interrupts
// - counter clear holds counters at zero
// - sample bit gates counters to second
`timescale 1ns/1ps
module e1_err_ctrl
    import e1_ctrl_pkg::*;
(
    input wire logic i_clk_sys,            // 100 MHz clock
    input wire logic i_srst,               // synchronous reset, high
    input wire logic psel,                 // apb select
    input wire logic penable,              // apb enable
    input wire logic pwrite,               // apb direction
    input wire logic [ADDR_W-1:0] paddr,   // apb byte address
    input wire logic [31:0] pwdata,        // apb write data
    output logic [31:0] prdata,            // apb read data
    output logic pready,                   // apb ready
    output logic pslverr,                  // apb error
    input wire logic i_bit_tick,           // next transmit bit
    input wire logic i_fas_slot,           // next fas word
    input wire logic i_nfas_slot,          // next nfas word
    input wire logic i_crc_mframe,         // next crc-4 multiframe
    input wire logic i_los,                // loss of signal state
    input wire logic i_frame_aligned,      // basic frame aligned
    input wire logic i_one_sec_tick,       // one second timer strobe
    output logic o_bpv_insert,             // one violation pulse
    output logic o_crc_corrupt,            // one crc corrupt pulse
    output logic o_align_corrupt,          // one fas error pulse
    output logic o_non_align_corrupt,      // one nfas bit two flip
    output logic o_payload_error,          // one payload error pulse
    output logic o_all_zero_transmit,      // suppress all pulses
    output logic o_dead_line_output,       // dead line pin level
    output logic o_soft_reset,             // device reset pulse
    output logic o_counter_clear,          // hold counters at zero
    output logic o_counter_update,         // counters may update
    output logic o_ext_osc_select,         // ttl oscillator input
    output logic o_irq,                    // interrupt level
    output logic o_irq_oe                  // interrupt pin driven
);
    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire [7:0] idx = paddr[ADDR_W-1:2];
    wire aligned_addr = (paddr[1:0] == 2'b00);
    wire hit_err = aligned_addr && (idx == IDX_ERR_INS);
    wire hit_glob = aligned_addr && (idx == IDX_GLOBAL);
    wire hit_stat = aligned_addr && (idx == IDX_IRQ_STATUS);
    wire hit_mask = aligned_addr && (idx == IDX_IRQ_MASK);
    wire hit_any = hit_err || hit_glob || hit_stat || hit_mask;
    wire wr_go = access && pwrite && pready && hit_any;
    wire wr_err = wr_go && hit_err;
    wire wr_glob = wr_go && hit_glob;
    wire wr_stat = wr_go && hit_stat;
    wire wr_mask = wr_go && hit_mask;
    wire [7:0] wbyte = pwdata[7:0];

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [7:0] err_ins;
    logic [7:0] glob;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic dead_q;

    // soft reset fires only on a zero to one change of the reset bit
    wire soft_rst = wr_glob && wbyte[GC_RESET] && !glob[GC_RESET];
    // any change of the acknowledge bit clears pending interrupts
    wire ack_toggle = wr_glob && (wbyte[GC_ACK] != glob[GC_ACK]);
    wire suspend = glob[GC_SUSPEND];

    // the reset bit itself reads back zero once defaults are restored
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || soft_rst) begin
            err_ins <= ERR_INS_RESET;
            glob <= GLOBAL_RESET;
        end else begin
            if (wr_err) begin
                err_ins <= wbyte & EI_WRITE_MASK;
            end
            if (wr_glob) begin
                glob <= wbyte & GC_WRITE_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // one-shot insertion bank
    // ----------------------------------------------------------------
    shot_if #(.N(SHOT_N)) sif ();
    assign sif.wr = wr_err;
    assign sif.flush = soft_rst;
    // slot order follows SH_* positions
    assign sif.new_bits = {wbyte[EI_PAYLOAD], wbyte[EI_NFAS], wbyte[EI_FAS],
                           wbyte[EI_CRC], wbyte[EI_BPV]};
    assign sif.old_bits = {err_ins[EI_PAYLOAD], err_ins[EI_NFAS], err_ins[EI_FAS],
                           err_ins[EI_CRC], err_ins[EI_BPV]};
    // violations and payload errors go at the next bit, words at their frame
    assign sif.opp = {i_bit_tick, i_nfas_slot, i_fas_slot, i_crc_mframe, i_bit_tick};

    one_shot_bank #(.N(SHOT_N)) u_shots (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .sif(sif)
    );

    assign o_bpv_insert = sif.fire[SH_BPV];
    assign o_crc_corrupt = sif.fire[SH_CRC];
    assign o_align_corrupt = sif.fire[SH_FAS];
    assign o_non_align_corrupt = sif.fire[SH_NFAS];
    assign o_payload_error = sif.fire[SH_PAYLOAD];

    // ----------------------------------------------------------------
    // level controls
    // ----------------------------------------------------------------
    // straight from register bits; the datapath owns the pulse suppression
    assign o_all_zero_transmit = err_ins[EI_ZERO];
    assign o_counter_clear = glob[GC_CNT_CLR];
    assign o_ext_osc_select = glob[GC_EXT_OSC];
    // with sampling on, counters move only on the one second strobe
    assign o_counter_update = !glob[GC_CNT_CLR] && (!glob[GC_SAMPLE] || i_one_sec_tick);

    // ----------------------------------------------------------------
    // dead line pin
    // ----------------------------------------------------------------
    wire dead_sel = err_ins[EI_DEAD_SEL];
    wire next_dead = i_los || (!dead_sel && !i_frame_aligned);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            dead_q <= 1'b0;
        end else begin
            dead_q <= next_dead;
        end
    end

    assign o_dead_line_output = dead_q;

    // ----------------------------------------------------------------
    // soft reset pulse
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= soft_rst;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    wire [IRQ_W-1:0] events = {|sif.fire, dead_q && !next_dead, !dead_q && next_dead};
    // suspended sources are dropped, not held for later
    wire [IRQ_W-1:0] set_bits = suspend ? '0 : events;
    wire [IRQ_W-1:0] w1c_bits = wr_stat ? wbyte[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] clr_bits = ack_toggle ? '1 : w1c_bits;
    // an event in the clearing cycle survives the clear
    wire [IRQ_W-1:0] next_status = (irq_status & ~clr_bits) | set_bits;
    wire irq_active = |(irq_status & irq_mask);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || soft_rst) begin
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
        end else begin
            irq_status <= next_status;
            if (wr_mask) begin
                irq_mask <= wbyte[IRQ_W-1:0];
            end
        end
    end

    // pin floats while suspended or when nothing unmasked is pending
    assign o_irq = irq_active;
    assign o_irq_oe = irq_active && !suspend;

    // ----------------------------------------------------------------
    // apb read path and answer
    // ----------------------------------------------------------------
    wire [7:0] rd_sel = hit_err ? err_ins :
                        hit_glob ? glob :
                        hit_stat ? {5'h00, irq_status} :
                        hit_mask ? {5'h00, irq_mask} : 8'h00;

    // read data and error are captured in setup so both come from flops
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_sel};
            pslverr <= !hit_any;
        end
    end

    assign pready = access;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    a_bpv_rise_arms: assert property (
        wr_err && wbyte[EI_BPV] && !err_ins[EI_BPV] && !soft_rst |=> sif.pending[SH_BPV]
    ) else $error("bpv rise did not arm");

    a_crc_single_pulse: assert property (
        o_crc_corrupt |=> !o_crc_corrupt
    ) else $error("crc corrupt longer than one cycle");

    a_fas_waits_slot: assert property (
        sif.pending[SH_FAS] && !i_fas_slot && !soft_rst |=> sif.pending[SH_FAS] && !o_align_corrupt
    ) else $error("fas shot left before its slot");

    a_nfas_fires: assert property (
        sif.pending[SH_NFAS] && i_nfas_slot && !soft_rst |=> o_non_align_corrupt
    ) else $error("nfas shot missed its slot");

    a_zero_follows: assert property (
        $rose(err_ins[EI_ZERO]) |-> o_all_zero_transmit ##1 (o_all_zero_transmit || $past(wr_err))
    ) else $error("all zero transmit not following bit");

    a_payload_fall_none: assert property (
        wr_err && !wbyte[EI_PAYLOAD] && !sif.pending[SH_PAYLOAD] |=> !sif.pending[SH_PAYLOAD]
    ) else $error("payload armed without rising change");

    a_dead_line_map: assert property (
        1'b1 |=> o_dead_line_output == ($past(i_los) ||
            (!$past(err_ins[EI_DEAD_SEL]) && !$past(i_frame_aligned)))
    ) else $error("dead line pin wrong source");

    a_reset_defaults: assert property (
        soft_rst |=> err_ins == ERR_INS_RESET && glob == GLOBAL_RESET && o_soft_reset
    ) else $error("soft reset did not restore defaults");

    a_suspend_floats: assert property (
        suspend |-> !o_irq_oe ##1 (irq_status == ($past(irq_status) & ~$past(clr_bits))
            || !suspend)
    ) else $error("interrupt active while suspended");

    a_ack_clears: assert property (
        ack_toggle && !(|set_bits) && !soft_rst |=> irq_status == IRQ_RESET && !o_irq_oe
    ) else $error("acknowledge left interrupts pending");

    a_counter_hold: assert property (
        glob[GC_CNT_CLR] |-> o_counter_clear && !o_counter_update
    ) else $error("counters not held while clearing");

    a_sample_gate: assert property (
        glob[GC_SAMPLE] && !i_one_sec_tick |-> !o_counter_update
    ) else $error("counter update outside one second strobe");
endmodule

// [dv/apb_host_model.sv]
// Purpose: host processor model driving the control registers over apb
// Assumes: caller enters each access right after a rising clock edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module apb_host_model
    import e1_ctrl_pkg::*;
(
    input wire logic i_clk_sys,      // bus clock
    input wire logic pready,         // slave ready
    input wire logic pslverr,        // slave error
    input wire logic [31:0] prdata,  // read data
    output logic psel,               // select
    output logic penable,            // enable
    output logic pwrite,             // direction
    output logic [ADDR_W-1:0] paddr, // byte address
    output logic [31:0] pwdata       // write data
);
    // ------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // ------------------------------------------------------------
    // one transfer: setup, access until ready, then one idle edge
    // ------------------------------------------------------------
    // the idle edge keeps back to back calls from assigning twice in a step
    task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        // reserved global bit always written as zero
        pwdata <= (idx == IDX_GLOBAL) ? (wdata & ~(32'h0000_0001 << GC_MUST_ZERO)) : wdata;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        do @(posedge i_clk_sys); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        @(posedge i_clk_sys);
    endtask
endmodule

// [dv/test_e1_error_insertion_and_global_control.sv]
// Purpose: self-checking bench for the error insertion and global control words
// Assumes: zero wait state apb, registered one-shot and dead line outputs
// Notes: framer strobes and line status are driven by the bench
`timescale 1ns/1ps
module test_e1_error_insert_and_global_control
    import e1_ctrl_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk_sys, i_srst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [SHOT_N-1:0] opp, shot_out;
    logic i_los, i_frame_aligned, i_one_sec_tick, bit_tick;
    logic o_bpv, o_crc, o_fas, o_nfas, o_pay, o_zero, o_dead, o_soft;
    logic o_clr, o_upd, o_osc, o_irq, o_irq_oe;
    int n_mismatch, compares, n_soft;
    // bpv and payload share the bit opportunity
    assign bit_tick = opp[SH_BPV] | opp[SH_PAYLOAD];
    assign shot_out = {o_pay, o_nfas, o_fas, o_crc, o_bpv};
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (o_soft === 1'b1) n_soft <= n_soft + 1;
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    e1_err_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_bit_tick(bit_tick), .i_fas_slot(opp[SH_FAS]),
        .i_nfas_slot(opp[SH_NFAS]), .i_crc_mframe(opp[SH_CRC]), .i_los(i_los),
        .i_frame_aligned(i_frame_aligned), .i_one_sec_tick(i_one_sec_tick),
        .o_bpv_insert(o_bpv), .o_crc_corrupt(o_crc), .o_align_corrupt(o_fas),
        .o_non_align_corrupt(o_nfas), .o_payload_error(o_pay), .o_all_zero_transmit(o_zero),
        .o_dead_line_output(o_dead), .o_soft_reset(o_soft), .o_counter_clear(o_clr),
        .o_counter_update(o_upd), .o_ext_osc_select(o_osc), .o_irq(o_irq), .o_irq_oe(o_irq_oe));
    apb_host_model u_host (.i_clk_sys(i_clk_sys), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_flag(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] data);
        logic [31:0] d;
        logic e;
        u_host.access(1'b1, idx, data, d, e);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] d;
        logic e;
        u_host.access(1'b0, idx, 32'h0000_0000, d, e);
        check_word(name, exp, d);
        check_flag("pslverr", exp_err, e);
    endtask
    // no fire before the strobe, one pulse after it, then quiet
    task automatic shot_chk(input int k, input logic [SHOT_N-1:0] exp);
        #1 check_word("shot idle", 32'h0000_0000, 32'(shot_out));
        @(posedge i_clk_sys);
        opp <= SHOT_N'(1 << k);
        @(posedge i_clk_sys);
        opp <= '0;
        #1 check_word("shot fire", 32'(exp), 32'(shot_out));
        @(posedge i_clk_sys);
        #1 check_word("shot after", 32'h0000_0000, 32'(shot_out));
        @(posedge i_clk_sys);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values;
        rd_chk("err_ins", IDX_ERR_INS, 32'(ERR_INS_RESET), 1'b0);
        rd_chk("global", IDX_GLOBAL, 32'(GLOBAL_RESET), 1'b0);
        rd_chk("irq status", IDX_IRQ_STATUS, 32'(IRQ_RESET), 1'b0);
        rd_chk("irq mask", IDX_IRQ_MASK, 32'h0000_0000, 1'b0);
        rd_chk("unmapped", 8'hff, 32'h0000_0000, 1'b1);
    endtask
    // rising, steady and falling writes for every single-error slot
    task automatic test_one_shots;
        int bitpos [SHOT_N] = '{EI_BPV, EI_CRC, EI_FAS, EI_NFAS, EI_PAYLOAD};
        for (int k = 0; k < SHOT_N; k++) begin
            wr(IDX_ERR_INS, 32'h0000_0001 << bitpos[k]);
            shot_chk(k, SHOT_N'(1 << k));
            wr(IDX_ERR_INS, 32'h0000_0001 << bitpos[k]);
            shot_chk(k, '0);
            wr(IDX_ERR_INS, 32'h0000_0000);
            shot_chk(k, '0);
        end
    endtask
    task automatic test_all_zero;
        wr(IDX_ERR_INS, 32'h0000_0001 << EI_ZERO);
        #1 check_flag("all zero on", 1'b1, o_zero);
        @(posedge i_clk_sys);
        wr(IDX_ERR_INS, 32'h0000_0000);
        #1 check_flag("all zero off", 1'b0, o_zero);
        @(posedge i_clk_sys);
    endtask
    task automatic test_dead_line;
        wr(IDX_ERR_INS, 32'h0000_0001 << EI_DEAD_SEL);
        i_frame_aligned <= 1'b0;
        step(3);
        #1 check_flag("dead frame loss sel1", 1'b0, o_dead);
        @(posedge i_clk_sys);
        i_los <= 1'b1;
        step(3);
        #1 check_flag("dead signal loss sel1", 1'b1, o_dead);
        @(posedge i_clk_sys);
        i_los <= 1'b0;
        wr(IDX_ERR_INS, 32'h0000_0000);
        step(2);
        #1 check_flag("dead frame loss sel0", 1'b1, o_dead);
        @(posedge i_clk_sys);
        i_frame_aligned <= 1'b1;
        step(3);
        #1 check_flag("dead aligned sel0", 1'b0, o_dead);
        @(posedge i_clk_sys);
    endtask
    task automatic test_interrupts;
        wr(IDX_IRQ_STATUS, 32'h0000_0007);
        rd_chk("status cleared", IDX_IRQ_STATUS, 32'h0000_0000, 1'b0);
        wr(IDX_IRQ_MASK, 32'h0000_0001 << ST_DEAD_RISE);
        i_los <= 1'b1;
        step(4);
        #1 check_flag("irq", 1'b1, o_irq);
        check_flag("irq oe", 1'b1, o_irq_oe);
        @(posedge i_clk_sys);
        wr(IDX_GLOBAL, 32'h0000_0001 << GC_SUSPEND);
        #1 check_flag("irq oe suspended", 1'b0, o_irq_oe);
        @(posedge i_clk_sys);
        i_los <= 1'b0;
        step(4);
        rd_chk("status suspended", IDX_IRQ_STATUS, 32'h0000_0001, 1'b0);
        wr(IDX_GLOBAL, 32'h0000_0001 << GC_ACK);
        #1 check_flag("irq ack rise", 1'b0, o_irq);
        @(posedge i_clk_sys);
        rd_chk("status ack", IDX_IRQ_STATUS, 32'h0000_0000, 1'b0);
        i_los <= 1'b1;
        step(4);
        #1 check_flag("irq again", 1'b1, o_irq);
        @(posedge i_clk_sys);
        wr(IDX_GLOBAL, 32'h0000_0000);
        #1 check_flag("irq ack fall", 1'b0, o_irq);
        @(posedge i_clk_sys);
        i_los <= 1'b0;
        step(3);
        wr(IDX_IRQ_STATUS, 32'h0000_0007);
        rd_chk("status w1c", IDX_IRQ_STATUS, 32'h0000_0000, 1'b0);
    endtask
    task automatic test_counters;
        wr(IDX_GLOBAL, 32'h0000_0001 << GC_CNT_CLR);
        #1 check_flag("counter clear", 1'b1, o_clr);
        check_flag("update in clear", 1'b0, o_upd);
        @(posedge i_clk_sys);
        wr(IDX_GLOBAL, (32'h0000_0001 << GC_SAMPLE) | (32'h0000_0001 << GC_EXT_OSC));
        #1 check_flag("counter run", 1'b0, o_clr);
        check_flag("update gated", 1'b0, o_upd);
        check_flag("ext osc", 1'b1, o_osc);
        @(posedge i_clk_sys);
        i_one_sec_tick <= 1'b1;
        #1 check_flag("update on second", 1'b1, o_upd);
        @(posedge i_clk_sys);
        i_one_sec_tick <= 1'b0;
        wr(IDX_GLOBAL, 32'h0000_0000);
        #1 check_flag("update free", 1'b1, o_upd);
        @(posedge i_clk_sys);
    endtask
    task automatic test_soft_reset;
        wr(IDX_ERR_INS, (32'h0000_0001 << EI_ZERO) | (32'h0000_0001 << EI_DEAD_SEL));
        wr(IDX_IRQ_MASK, 32'h0000_0007);
        wr(IDX_GLOBAL, 32'h0000_0001 << GC_RESET);
        step(2);
        #1 check_word("soft reset pulses", 32'h0000_0001, n_soft);
        check_flag("all zero after reset", 1'b0, o_zero);
        @(posedge i_clk_sys);
        rd_chk("err_ins after reset", IDX_ERR_INS, 32'h0000_0000, 1'b0);
        rd_chk("mask after reset", IDX_IRQ_MASK, 32'h0000_0000, 1'b0);
        rd_chk("global after reset", IDX_GLOBAL, 32'h0000_0000, 1'b0);
    endtask
    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic results;
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // the full run needs well under a thousand cycles
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        results;
    end
    initial begin
        i_clk_sys = 1'b0;
        i_srst = 1'b1;
        opp = '0;
        i_los = 1'b0;
        i_frame_aligned = 1'b1;
        i_one_sec_tick = 1'b0;
        n_mismatch = 0;
        compares = 0;
        n_soft = 0;
        step(6);
        i_srst <= 1'b0;
        @(posedge i_clk_sys);
        test_reset_values;
        test_one_shots;
        test_all_zero;
        test_dead_line;
        test_interrupts;
        test_counters;
        test_soft_reset;
        results;
    end
endmodule
